// ==== include/hsr_pkg.sv ====
/*
 Package for the host status register block: register offset, bit positions,
 reset values and the packed carriers for schedule-engine events and levels.
 Assumes a 32-bit AXI4-Lite register bus and a single 125 MHz clock.
*/
// Functional notes
// RQ1: Status register at byte offset 24h, 32 bits; bits 31-16 and 11-6 reserved.
// RQ2: Per-transfer wire outcome is never reported here; descriptors hold it.
// RQ3: Event flags clear on write-one; otherwise they stay set.
// RQ4: Software writes zero into all reserved bit positions.
// RQ5: Bit 15 read-only, reset 0, mirrors actual async schedule running state.
// RQ6: Bit 14 read-only, reset 0, mirrors actual periodic schedule running state.
// RQ7: Bit 13 read-only, reset 0, flags empty asynchronous schedule detection.
// RQ8: Bit 12 read-only, reset 1, reads 0 whenever run/stop is 1.
// RQ9: Halted sets only after execution truly stops once run/stop cleared.
// RQ10: After doorbell write, bit 5 sets at next async schedule advance.
// RQ11: Bit 4 sets on serious host bus error: parity, master or target abort.
// RQ12: Host system error clears run/stop in the command register.
// RQ13: Bit 3 sets each time frame list index wraps to zero.
// RQ14: 1024 entries: frame index bit 13 toggle; 512: bit 12 toggle.
// RQ15: Bit 2 sets on change bit rise of owned port, or force-resume rise.
// RQ16: On D3-to-D0 reload port change flag with OR of port change bits.
// RQ17: Bit 1 sets when a completed transaction ends in error.
// RQ18: Errored descriptor with completion interrupt request sets bits 1 and 0.
// RQ19: Bit 0 sets on retiring descriptor with completion request, or short packet.
// RQ20: Interrupt raised while host system error flag and its enable are set.
// RQ21: Writing zero leaves a flag alone; hardware set beats software clear.
package hsr_pkg;
   localparam logic [11:0] HSR_STATUS_OFS = 12'h024;
   localparam int HSR_ADDR_W = 12;
   localparam int HSR_BIT_XFER_DONE = 0;
   localparam int HSR_BIT_XFER_ERR = 1;
   localparam int HSR_BIT_PORT_CHG = 2;
   localparam int HSR_BIT_ROLLOVER = 3;
   localparam int HSR_BIT_SYS_ERR = 4;
   localparam int HSR_BIT_ASYNC_ADV = 5;
   localparam int HSR_BIT_HALTED = 12;
   localparam int HSR_BIT_EMPTY_DET = 13;
   localparam int HSR_BIT_PER_STATE = 14;
   localparam int HSR_BIT_ASY_STATE = 15;
   localparam logic [5:0] HSR_EVENT_RESET = 6'h00;
   localparam logic HSR_HALTED_RESET = 1'b1;
   localparam logic [1:0] HSR_FLS_1024 = 2'h0;
   localparam logic [1:0] HSR_FLS_512 = 2'h1;
   localparam logic [1:0] HSR_FLS_256 = 2'h2;
   localparam int HSR_FIDX_BIT_1024 = 13;
   localparam int HSR_FIDX_BIT_512 = 12;
   localparam int HSR_FIDX_BIT_256 = 11;
   localparam logic [1:0] HSR_RESP_OKAY = 2'h0;
   localparam logic [1:0] HSR_RESP_SLVERR = 2'h2;

   // Schedule engine strobes, one-cycle pulses
   typedef struct packed {
      logic desc_retired_ioc;
      logic short_packet;
      logic xact_error;
      logic error_ioc;
      logic async_advanced;
      logic bus_parity_err;
      logic bus_master_abort;
      logic bus_target_abort;
   } hsr_sched_ev_s;

   // Schedule engine levels
   typedef struct packed {
      logic exec_stopped;
      logic async_running;
      logic periodic_running;
      logic async_empty;
   } hsr_sched_lvl_s;
endpackage

// ==== design/hsr_port_change.sv ====
/*
 Port change detector: rising-edge detection over root hub ports not owned by a companion.
 Assumes port inputs are already on aclk.
*/
`timescale 1ns/1ps
module hsr_port_change #(
   parameter int N_PORTS = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [N_PORTS-1:0] change_any,
   input wire logic [N_PORTS-1:0] companion_owned,
   input wire logic [N_PORTS-1:0] force_resume,
   input wire logic [N_PORTS-1:0] force_resume_jk,
   output logic detect
);
   logic [N_PORTS-1:0] chg_q;
   logic [N_PORTS-1:0] fpr_q;
   logic [N_PORTS-1:0] rise_chg;
   logic [N_PORTS-1:0] rise_fpr;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         chg_q <= '0;
         fpr_q <= '0;
      end
      else
      begin
         chg_q <= change_any;
         fpr_q <= force_resume;
      end
   end

   // Ports handed to a companion never report here
   assign rise_chg = change_any & ~chg_q & ~companion_owned; // RQ15
   assign rise_fpr = force_resume & ~fpr_q & force_resume_jk & ~companion_owned; // RQ15
   assign detect = |rise_chg | |rise_fpr;
endmodule

// ==== design/hsr_status.sv ====
/*
 Host status register bank with AXI4-Lite slave.
 Holds write-one-to-clear event flags and read-only schedule state mirrors.
 Assumes the schedule engine, command register and port logic are outside and
 run on aclk; the frame index arrives as a same-clock counter value.
*/
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module hsr_status
#(
   parameter int N_PORTS = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [11:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [11:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Command register view
   input wire logic run_stop,
   input wire logic [1:0] frame_list_size,
   input wire logic [13:0] frame_index,
   input wire logic async_advance_doorbell,
   input wire logic host_system_error_en,
   // Schedule engine
   input wire hsr_pkg::hsr_sched_ev_s sched_ev,
   input wire hsr_pkg::hsr_sched_lvl_s sched_lvl,
   // Ports
   input wire logic [N_PORTS-1:0] port_change_any,
   input wire logic [N_PORTS-1:0] companion_owned,
   input wire logic [N_PORTS-1:0] force_resume,
   input wire logic [N_PORTS-1:0] force_resume_jk,
   input wire logic d3_to_d0,
   input wire logic [N_PORTS-1:0] port_change_level,
   // Outputs to the rest of the controller
   output logic run_stop_clear,
   output logic doorbell_ack,
   output logic host_system_error_irq,
   output logic [31:0] host_status
);
   import hsr_pkg::*;

   typedef enum logic [2:0]
   {
      HSR_W_IDLE = 3'b001,
      HSR_W_DATA = 3'b010,
      HSR_W_RESP = 3'b100
   } hsr_wstate_e;

   hsr_wstate_e wst_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_fire;
   logic wr_hit;
   logic [5:0] clr_mask;

   logic xfer_done_q;
   logic xfer_err_q;
   logic port_chg_q;
   logic rollover_q;
   logic sys_err_q;
   logic async_adv_q;
   logic halted_q;
   logic asy_state_q;
   logic per_state_q;
   logic empty_det_q;
   logic doorbell_pend_q;
   logic fidx_bit_q;
   logic fidx_bit;
   logic port_detect;
   logic sys_err_ev;
   logic [31:0] status_w;

   hsr_port_change #(.N_PORTS(N_PORTS)) u_port_change (
      .aclk(aclk),
      .aresetn(aresetn),
      .change_any(port_change_any),
      .companion_owned(companion_owned),
      .force_resume(force_resume),
      .force_resume_jk(force_resume_jk),
      .detect(port_detect)
   );

   // Write channel: either order; each ready flop is low while its item is held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_q <= HSR_W_IDLE;
         s_awready <= 1'b1;
         s_wready <= 1'b1;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_bvalid <= 1'b0;
         s_bresp <= HSR_RESP_OKAY;
      end
      else
      begin
         case (wst_q)
            HSR_W_IDLE, HSR_W_DATA:
            begin
               if (s_awvalid && s_awready)
               begin
                  awaddr_q <= s_awaddr;
                  s_awready <= 1'b0;
               end
               if (s_wvalid && s_wready)
               begin
                  wdata_q <= s_wdata;
                  wstrb_q <= s_wstrb;
                  s_wready <= 1'b0;
               end
               if (wr_fire)
               begin
                  wst_q <= HSR_W_RESP;
                  s_bvalid <= 1'b1;
                  s_bresp <= wr_hit ? HSR_RESP_OKAY : HSR_RESP_SLVERR;
               end
               else if (!s_awready || !s_wready)
                  wst_q <= HSR_W_DATA;
            end
            HSR_W_RESP:
            begin
               if (s_bready)
               begin
                  s_bvalid <= 1'b0;
                  s_awready <= 1'b1;
                  s_wready <= 1'b1;
                  wst_q <= HSR_W_IDLE;
               end
            end
            default:
               wst_q <= HSR_W_IDLE;
         endcase
      end
   end

   assign wr_fire = !s_awready && !s_wready && (wst_q != HSR_W_RESP);
   assign wr_hit = (awaddr_q[11:2] == HSR_STATUS_OFS[11:2]); // RQ1
   // Only low byte carries clearable flags; reserved bits ignored
   assign clr_mask = (wr_fire && wr_hit && wstrb_q[0]) ? wdata_q[5:0] : 6'h00; // RQ3 RQ4

   // Read channel, one word at a time; ready flop is always the inverse of s_rvalid
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_arready <= 1'b1;
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= HSR_RESP_OKAY;
      end
      else if (s_arvalid && s_arready)
      begin
         s_rvalid <= 1'b1;
         s_arready <= 1'b0;
         if (s_araddr[11:2] == HSR_STATUS_OFS[11:2]) // RQ1
         begin
            s_rdata <= status_w;
            s_rresp <= HSR_RESP_OKAY;
         end
         else
         begin
            s_rdata <= '0;
            s_rresp <= HSR_RESP_SLVERR;
         end
      end
      else if (s_rvalid && s_rready)
      begin
         s_rvalid <= 1'b0;
         s_arready <= 1'b1;
      end
   end

   // Transfer events; per-packet wire status is not kept here (RQ2)
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         xfer_done_q <= HSR_EVENT_RESET[HSR_BIT_XFER_DONE];
      else if (sched_ev.desc_retired_ioc || sched_ev.short_packet
               || (sched_ev.xact_error && sched_ev.error_ioc)) // RQ19 RQ18
         xfer_done_q <= 1'b1; // RQ21
      else if (clr_mask[HSR_BIT_XFER_DONE])
         xfer_done_q <= 1'b0; // RQ3
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         xfer_err_q <= HSR_EVENT_RESET[HSR_BIT_XFER_ERR];
      else if (sched_ev.xact_error)
         xfer_err_q <= 1'b1; // RQ17 RQ21
      else if (clr_mask[HSR_BIT_XFER_ERR])
         xfer_err_q <= 1'b0; // RQ3
   end

   // Port change; D3-to-D0 reload covers the flag lost in the main well
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port_chg_q <= HSR_EVENT_RESET[HSR_BIT_PORT_CHG];
      else if (port_detect)
         port_chg_q <= 1'b1; // RQ15 RQ21
      else if (d3_to_d0)
         port_chg_q <= |port_change_level; // RQ16
      else if (clr_mask[HSR_BIT_PORT_CHG])
         port_chg_q <= 1'b0; // RQ3
   end

   // Frame list rollover watch bit chosen by list size
   assign fidx_bit = (frame_list_size == HSR_FLS_1024) ? frame_index[HSR_FIDX_BIT_1024] // RQ14
                     : (frame_list_size == HSR_FLS_512) ? frame_index[HSR_FIDX_BIT_512] // RQ14
                     : frame_index[HSR_FIDX_BIT_256];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fidx_bit_q <= 1'b0;
      else
         fidx_bit_q <= fidx_bit;
   end

   // A size change may look like a toggle; software changes size only halted
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rollover_q <= HSR_EVENT_RESET[HSR_BIT_ROLLOVER];
      else if (fidx_bit != fidx_bit_q)
         rollover_q <= 1'b1; // RQ13 RQ21
      else if (clr_mask[HSR_BIT_ROLLOVER])
         rollover_q <= 1'b0; // RQ3
   end

   assign sys_err_ev = sched_ev.bus_parity_err || sched_ev.bus_master_abort || sched_ev.bus_target_abort;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sys_err_q <= HSR_EVENT_RESET[HSR_BIT_SYS_ERR];
      else if (sys_err_ev)
         sys_err_q <= 1'b1; // RQ11 RQ21
      else if (clr_mask[HSR_BIT_SYS_ERR])
         sys_err_q <= 1'b0; // RQ3
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_stop_clear <= 1'b0;
         host_system_error_irq <= 1'b0;
      end
      else
      begin
         run_stop_clear <= sys_err_ev; // RQ12
         host_system_error_irq <= sys_err_q && host_system_error_en; // RQ20
      end
   end

   // Doorbell armed until the next async advance
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         doorbell_pend_q <= 1'b0;
         async_adv_q <= HSR_EVENT_RESET[HSR_BIT_ASYNC_ADV];
         doorbell_ack <= 1'b0;
      end
      else
      begin
         doorbell_ack <= 1'b0;
         if (doorbell_pend_q && sched_ev.async_advanced)
         begin
            doorbell_pend_q <= 1'b0;
            async_adv_q <= 1'b1; // RQ10 RQ21
            doorbell_ack <= 1'b1;
         end
         else
         begin
            if (async_advance_doorbell)
               doorbell_pend_q <= 1'b1;
            if (clr_mask[HSR_BIT_ASYNC_ADV])
               async_adv_q <= 1'b0; // RQ3
         end
      end
   end

   // State mirrors
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         halted_q <= HSR_HALTED_RESET;
         asy_state_q <= 1'b0;
         per_state_q <= 1'b0;
         empty_det_q <= 1'b0;
      end
      else
      begin
         if (run_stop)
            halted_q <= 1'b0; // RQ8
         else if (sched_lvl.exec_stopped)
            halted_q <= 1'b1; // RQ9
         asy_state_q <= sched_lvl.async_running; // RQ5
         per_state_q <= sched_lvl.periodic_running; // RQ6
         empty_det_q <= sched_lvl.async_empty; // RQ7
      end
   end

   assign status_w = {16'h0000, asy_state_q, per_state_q, empty_det_q, halted_q, 6'h00, // RQ1
                      async_adv_q, sys_err_q, rollover_q, port_chg_q, xfer_err_q, xfer_done_q};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         host_status <= 32'h0000_1000;
      else
         host_status <= status_w;
   end
endmodule

// ==== tb/hsr_status_chk.sv ====
/*
 Port-level concurrent checks for the host status register.
 Assumes one aclk domain and is bound into hsr_status below.
*/
`timescale 1ns/1ps
module hsr_status_chk
   import hsr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [11:0] s_araddr,
   input wire logic s_rvalid,
   input wire logic [1:0] s_rresp,
   input wire logic s_bvalid,
   input wire logic d3_to_d0,
   input wire logic run_stop,
   input wire logic [1:0] frame_list_size,
   input wire logic [13:0] frame_index,
   input wire logic host_system_error_en,
   input wire hsr_pkg::hsr_sched_ev_s sched_ev,
   input wire hsr_pkg::hsr_sched_lvl_s sched_lvl,
   input wire logic run_stop_clear,
   input wire logic doorbell_ack,
   input wire logic host_system_error_irq,
   input wire logic [31:0] host_status
);
   logic bus_err;
   logic done_ev;
   assign bus_err = sched_ev.bus_parity_err | sched_ev.bus_master_abort | sched_ev.bus_target_abort;
   assign done_ev = sched_ev.desc_retired_ioc | sched_ev.short_packet | (sched_ev.xact_error & sched_ev.error_ioc);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Flags land internally on the strobe edge, the image one edge later
   a_reserved_zero: assert property (host_status[31:16] == 16'h0 && host_status[11:6] == 6'h0)
      else $error("reserved status bits set");
   a_read_resp: assert property (s_arvalid && s_arready |=> s_rvalid &&
      s_rresp == (($past(s_araddr) == HSR_STATUS_OFS) ? HSR_RESP_OKAY : HSR_RESP_SLVERR))
      else $error("read response wrong");
   a_flag_sticky: assert property (|($past(host_status[5:0]) & ~host_status[5:0]) |->
      $past(s_bvalid) || $past(s_bvalid, 2) || $past(d3_to_d0, 2))
      else $error("event flag fell without a write");
   a_state_mirror: assert property (host_status[15:13] ==
      $past({sched_lvl.async_running, sched_lvl.periodic_running, sched_lvl.async_empty}, 2))
      else $error("schedule state bits do not follow");
   a_halt_running: assert property (run_stop |-> ##2 !host_status[HSR_BIT_HALTED])
      else $error("halted while running");
   a_halt_waits: assert property ($rose(host_status[HSR_BIT_HALTED]) |->
      $past(sched_lvl.exec_stopped, 2) && !$past(run_stop, 2)) else $error("halted before stop");
   a_doorbell_flag: assert property (doorbell_ack |=> host_status[HSR_BIT_ASYNC_ADV])
      else $error("advance flag missing");
   a_doorbell_pulse: assert property ($rose(host_status[HSR_BIT_ASYNC_ADV]) |-> $past(doorbell_ack))
      else $error("advance flag rose without acknowledge");
   a_sys_err_flag: assert property (bus_err |-> ##2 host_status[HSR_BIT_SYS_ERR])
      else $error("system error flag missing");
   a_run_stop_clr: assert property (bus_err |=> run_stop_clear)
      else $error("run stop not cleared");
   a_rollover_flag: assert property (((frame_list_size == HSR_FLS_1024 && $changed(frame_index[13])) ||
      (frame_list_size == HSR_FLS_512 && $changed(frame_index[12]))) |-> ##2 host_status[HSR_BIT_ROLLOVER])
      else $error("rollover flag missing");
   a_xfer_err: assert property (sched_ev.xact_error |-> ##2 host_status[HSR_BIT_XFER_ERR])
      else $error("transfer error flag missing");
   a_xfer_done: assert property (done_ev |-> ##2 host_status[HSR_BIT_XFER_DONE])
      else $error("transfer complete flag missing");
   a_irq_gate: assert property (host_system_error_irq ==
      (host_status[HSR_BIT_SYS_ERR] && $past(host_system_error_en))) else $error("irq gating wrong");
   c_bus_err: cover property (bus_err ##2 host_status[HSR_BIT_SYS_ERR]);
   c_doorbell: cover property (doorbell_ack);
   c_halt: cover property ($rose(host_status[HSR_BIT_HALTED]));
endmodule

bind hsr_status hsr_status_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rresp(s_rresp), .s_bvalid(s_bvalid),
   .d3_to_d0(d3_to_d0), .run_stop(run_stop), .frame_list_size(frame_list_size), .frame_index(frame_index),
   .host_system_error_en(host_system_error_en), .sched_ev(sched_ev), .sched_lvl(sched_lvl),
   .run_stop_clear(run_stop_clear), .doorbell_ack(doorbell_ack),
   .host_system_error_irq(host_system_error_irq), .host_status(host_status));

// ==== tb/test_ehci_host_status_register.sv ====
/*
 Testbench for the host status register: AXI4-Lite master, event rows, hand tests.
 Assumes the hsr_status design and its package; aclk 125 MHz.
*/
`timescale 1ns/1ps
module test_ehci_host_status_register;
   import hsr_pkg::*;
   logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awready, s_wready;
   logic s_bvalid, s_arready, s_rvalid, run_stop, async_advance_doorbell, host_system_error_en, d3_to_d0;
   logic run_stop_clear, doorbell_ack, host_system_error_irq;
   logic [11:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, host_status, rd_data;
   logic [3:0] s_wstrb, companion_owned, force_resume, force_resume_jk, port_change_any, port_change_level;
   logic [1:0] s_bresp, s_rresp, frame_list_size, rd_resp, wr_resp;
   logic [13:0] frame_index;
   hsr_sched_ev_s sched_ev;
   hsr_sched_lvl_s sched_lvl;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int i;
   // Event strobe beside the flags it should leave set
   logic [39:0] rows [8] = '{{8'h80, 32'h1}, {8'h40, 32'h1}, {8'h20, 32'h2}, {8'h30, 32'h3},
      {8'h08, 32'h0}, {8'h04, 32'h10}, {8'h02, 32'h10}, {8'h01, 32'h10}};
   hsr_status dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
      .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .run_stop(run_stop), .frame_list_size(frame_list_size), .frame_index(frame_index),
      .async_advance_doorbell(async_advance_doorbell), .host_system_error_en(host_system_error_en),
      .sched_ev(sched_ev), .sched_lvl(sched_lvl), .port_change_any(port_change_any),
      .companion_owned(companion_owned), .force_resume(force_resume), .force_resume_jk(force_resume_jk),
      .d3_to_d0(d3_to_d0), .port_change_level(port_change_level), .run_stop_clear(run_stop_clear),
      .doorbell_ack(doorbell_ack), .host_system_error_irq(host_system_error_irq), .host_status(host_status));
   always #4 aclk = ~aclk;
   task automatic results;
      $display("tests_run %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Run should take a few hundred cycles
   always @(posedge aclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         results();
      end
   end
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_awvalid && s_awready)
            s_awvalid <= 1'b0;
         if (s_wvalid && s_wready)
            s_wvalid <= 1'b0;
      end
      while (!s_bvalid);
      wr_resp = s_bresp;
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_arvalid && s_arready)
            s_arvalid <= 1'b0;
      end
      while (!s_rvalid);
      rd_data = s_rdata;
      rd_resp = s_rresp;
      s_rready <= 1'b0;
   endtask
   task automatic rchk(input logic [31:0] e);
      rd(HSR_STATUS_OFS);
      chk({rd_resp, rd_data}, {HSR_RESP_OKAY, e});
   endtask
   task automatic ev(input logic [7:0] v);
      @(posedge aclk);
      sched_ev <= hsr_sched_ev_s'(v);
      @(posedge aclk);
      sched_ev <= '0;
   endtask
   initial
   begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, run_stop, async_advance_doorbell, d3_to_d0} = '0;
      {s_awaddr, s_araddr, s_wdata, frame_list_size, frame_index} = '0;
      {companion_owned, force_resume, force_resume_jk, port_change_any, port_change_level} = '0;
      s_wstrb = 4'hf;
      host_system_error_en = 1'b1;
      sched_ev = '0;
      sched_lvl = hsr_sched_lvl_s'(4'h8);
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      chk({2'h0, host_status}, {2'h0, 32'h1000});
      rchk(32'h1000);
      for (i = 0; i < 8; i++)
      begin
         ev(rows[i][39:32]);
         rchk(rows[i][31:0] | 32'h1000);
         chk({33'h0, host_system_error_irq}, {33'h0, rows[i][4]});
         wr(HSR_STATUS_OFS, 32'h3f);
         rchk(32'h1000);
      end
      rd(12'h020);
      chk({rd_resp, rd_data}, {HSR_RESP_SLVERR, 32'h0});
      ev(8'h20);
      wr(12'h028, 32'h3f);
      chk({32'h0, wr_resp}, {32'h0, HSR_RESP_SLVERR});
      wr(HSR_STATUS_OFS, 32'h1);
      rchk(32'h1002);
      wr(HSR_STATUS_OFS, 32'h2);
      host_system_error_en <= 1'b0;
      ev(8'h04);
      rchk(32'h1010);
      chk({33'h0, host_system_error_irq}, 34'h0);
      wr(HSR_STATUS_OFS, 32'h10);
      @(posedge aclk);
      async_advance_doorbell <= 1'b1;
      @(posedge aclk);
      async_advance_doorbell <= 1'b0;
      ev(8'h08);
      rchk(32'h1020);
      wr(HSR_STATUS_OFS, 32'h20);
      // Other size bit toggled first: it must not count
      for (i = 0; i < 3; i++)
      begin
         @(posedge aclk);
         frame_list_size <= i[1:0];
         @(posedge aclk);
         frame_index <= frame_index ^ ((i == 1) ? 14'h2000 : 14'h1000);
         rchk(32'h1000);
         @(posedge aclk);
         frame_index <= frame_index ^ (14'h2000 >> i);
         rchk(32'h1008);
         wr(HSR_STATUS_OFS, 32'h8);
      end
      @(posedge aclk);
      companion_owned <= 4'h1;
      port_change_any <= 4'h1;
      rchk(32'h1000);
      @(posedge aclk);
      port_change_any <= 4'h3;
      rchk(32'h1004);
      wr(HSR_STATUS_OFS, 32'h4);
      @(posedge aclk);
      force_resume <= 4'h4;
      force_resume_jk <= 4'h4;
      rchk(32'h1004);
      wr(HSR_STATUS_OFS, 32'h4);
      @(posedge aclk);
      port_change_level <= 4'h8;
      d3_to_d0 <= 1'b1;
      @(posedge aclk);
      d3_to_d0 <= 1'b0;
      rchk(32'h1004);
      wr(HSR_STATUS_OFS, 32'h4);
      @(posedge aclk);
      run_stop <= 1'b1;
      sched_lvl <= hsr_sched_lvl_s'(4'h7);
      rchk(32'he000);
      run_stop <= 1'b0;
      rchk(32'he000);
      sched_lvl <= hsr_sched_lvl_s'(4'h8);
      rchk(32'h1000);
      ev(8'h20);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk({2'h0, host_status}, {2'h0, 32'h1000});
      results();
   end
endmodule
